// file: src/spds_ctrl.sv
/*
 * Memory controller end of the split-port DDR link: makes the clocks,
 * issues burst-of-four reads and writes, gathers read bursts.
 * Assumes one request per handshake from the user, held while ready is low.
 */
`timescale 1ns/10ps
module spds_ctrl
	import spds_pkg::*;
#(
	parameter int DATA_W = SPDS_DATA_W,
	parameter int ADDR_W = SPDS_ADDR_W,
	parameter bit SINGLE_CLK = 1'b0
) (
	// Clock and reset
	input wire logic clk_sys_in,
	input wire logic rst_b_in,
	// Link
	spds_if.ctrl link,
	// Write requests
	input wire logic wr_req_in,
	input wire logic [ADDR_W-1:0] wr_addr_in,
	input wire logic [SPDS_BURST_LEN*DATA_W-1:0] wr_data_in,
	input wire logic [SPDS_BURST_LEN*SPDS_LANE_MASK_W-1:0] wr_mask_n_in,
	output logic wr_ready_out,
	// Read requests and answers
	input wire logic rd_req_in,
	input wire logic [ADDR_W-1:0] rd_addr_in,
	output logic rd_ready_out,
	output logic [SPDS_BURST_LEN*DATA_W-1:0] rd_data_out,
	output logic rd_valid_out
);

	// ==========================================================
	// Clocks, one half period per cycle
	logic k_q;

	always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			k_q <= 1'b0;
		end else begin
			k_q <= ~k_q;
		end
	end

	assign link.k = k_q;
	assign link.k_n = ~k_q;
	assign link.c = k_q;
	assign link.c_n = ~k_q;
	assign link.single_clk_mode = SINGLE_CLK;

	// ==========================================================
	// Issue; requests start only on the edge before a true edge
	logic rd_gap_q;
	logic wr_on_q;
	logic [1:0] wr_cnt_q;
	logic rd_fire;
	logic wr_fire;
	logic wr_busy;

	assign wr_busy = wr_on_q & (wr_cnt_q != SPDS_BEAT_LAST);
	assign rd_ready_out = ~k_q & ~rd_gap_q;
	assign rd_fire = rd_req_in & rd_ready_out;
	assign wr_ready_out = ~k_q & ~wr_busy & ~rd_fire;
	assign wr_fire = wr_req_in & wr_ready_out;

	always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			rd_gap_q <= 1'b0;
		end else if (rd_fire) begin
			rd_gap_q <= 1'b1;
		end else if (!k_q) begin
			rd_gap_q <= 1'b0;
		end
	end

	logic rps_n_q;
	logic wps_n_q;
	logic [ADDR_W-1:0] addr_q;

	always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			rps_n_q <= SPDS_SEL_IDLE;
			wps_n_q <= SPDS_SEL_IDLE;
			addr_q <= '0;
		end else begin
			rps_n_q <= ~rd_fire;
			wps_n_q <= ~wr_fire;
			if (rd_fire) begin
				addr_q <= rd_addr_in;
			end else if (wr_fire) begin
				addr_q <= wr_addr_in;
			end
		end
	end

	// ==========================================================
	// Write beats with their masks
	logic [SPDS_BURST_LEN*DATA_W-1:0] wdata_q;
	logic [SPDS_BURST_LEN*SPDS_LANE_MASK_W-1:0] wmask_q;
	logic [DATA_W-1:0] d_q;
	logic [SPDS_LANE_MASK_W-1:0] m_q;
	logic [1:0] nxt;

	assign nxt = wr_cnt_q + SPDS_BEAT_NEXT;

	always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			wr_on_q <= 1'b0;
			wr_cnt_q <= SPDS_BEAT_FIRST;
			wdata_q <= '0;
			wmask_q <= '1;
			d_q <= '0;
			m_q <= '1;
		end else if (wr_fire) begin
			wr_on_q <= 1'b1;
			wr_cnt_q <= SPDS_BEAT_FIRST;
			wdata_q <= wr_data_in;
			wmask_q <= wr_mask_n_in;
			d_q <= wr_data_in[DATA_W-1:0];
			m_q <= wr_mask_n_in[SPDS_LANE_MASK_W-1:0];
		end else if (wr_on_q) begin
			wr_cnt_q <= nxt;
			d_q <= wdata_q[nxt*DATA_W +: DATA_W];
			m_q <= wmask_q[nxt*SPDS_LANE_MASK_W +: SPDS_LANE_MASK_W];
			if (wr_cnt_q == SPDS_BEAT_LAST) begin
				wr_on_q <= 1'b0;
				m_q <= '1;
			end
		end
	end

	assign link.read_port_select_n = rps_n_q;
	assign link.write_port_select_n = wps_n_q;
	assign link.addr = addr_q;
	assign link.d = d_q;

	generate
		if (DATA_W == SPDS_NIB_CFG_W) begin : g_nib
			assign link.nibble_write_mask_n = m_q[SPDS_NIB_MASK_W-1:0];
			assign link.lane_write_mask_n = '1;
		end else begin : g_lane
			assign link.nibble_write_mask_n = '1;
			assign link.lane_write_mask_n = m_q;
		end
	endgenerate

	// ==========================================================
	// Read gather, one beat per driven cycle
	logic [1:0] rd_cnt_q;
	logic rd_valid_q;
	logic [SPDS_BURST_LEN*DATA_W-1:0] rd_data_q;

	always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			rd_cnt_q <= SPDS_BEAT_FIRST;
			rd_valid_q <= 1'b0;
			rd_data_q <= '0;
		end else begin
			rd_valid_q <= 1'b0;
			if (!link.q_oe_n) begin
				rd_data_q[rd_cnt_q*DATA_W +: DATA_W] <= link.q;
				rd_cnt_q <= rd_cnt_q + SPDS_BEAT_NEXT;
				rd_valid_q <= (rd_cnt_q == SPDS_BEAT_LAST);
			end
		end
	end

	assign rd_data_out = rd_data_q;
	assign rd_valid_out = rd_valid_q;

endmodule

// file: src/spds_device.sv
/*
 * SRAM end of the split-port DDR link: burst-of-four writes and reads
 * on one shared address bus, flip-flop storage.
 * Assumes the controller drives the clocks every cycle and keeps to the
 * request spacing of the link.
 */
// Function
// R1 - Low write select at true edge starts write
// R2 - Deselected write port ignores write data
// R3 - x8: two nibble masks gate [3:0],[7:4]
// R4 - Masked nibble is discarded, stored nibble kept
// R5 - Wider widths: byte masks gate nine-bit lanes
// R6 - Masked lane ignored, stored byte kept
// R7 - Masks sampled on same edge as data
// R8 - One shared address, captured at true edge
// R9 - Address width 19, 18 or 17 bits
// R10 - Address ignored when its port deselected
// R11 - Read data on both output clock edges
// R12 - Deselected read port tri-states outputs
// R13 - Low read select at true edge starts read
// R14 - Finish read, release after next true edge
// R15 - Each read returns four sequential beats
// R16 - Inputs captured on both input clock edges
// R17 - Writes carry four beats with own masks
`timescale 1ns/10ps
module spds_device
	import spds_pkg::*;
#(
	parameter int DATA_W = SPDS_DATA_W,
	parameter int ADDR_W = SPDS_ADDR_W
) (
	// Clock and reset
	input wire logic clk_sys_in,
	input wire logic rst_b_in,
	// Link
	spds_if.device link,
	// Status
	output logic write_busy_out,
	output logic read_busy_out
);

	// ==========================================================
	// Geometry
	localparam int LANE_W = (DATA_W == SPDS_NIB_CFG_W) ? SPDS_NIB_W : SPDS_LANE_W;
	localparam int MASK_W = DATA_W / LANE_W;
	localparam int DEPTH = SPDS_BURST_LEN << ADDR_W; // R9

	logic [DATA_W-1:0] mem [DEPTH];
	logic [MASK_W-1:0] wmask_n;

	generate
		if (LANE_W == SPDS_NIB_W) begin : g_nib
			assign wmask_n = link.nibble_write_mask_n[MASK_W-1:0]; // R3
		end else begin : g_lane
			assign wmask_n = link.lane_write_mask_n[MASK_W-1:0]; // R5
		end
	endgenerate

	// ==========================================================
	// Pin decode
	logic true_in_edge;
	logic wr_sel;
	logic rd_sel;

	assign true_in_edge = link.k; // R8 R16
	assign wr_sel = ~link.write_port_select_n; // R1
	assign rd_sel = ~link.read_port_select_n; // R13

	// ==========================================================
	// Write port
	logic wr_act_q;
	logic [1:0] wr_cnt_q;
	logic [ADDR_W-1:0] wr_addr_q;
	logic any_edge;
	logic wr_start;
	logic wr_beat;
	logic [1:0] wr_idx;
	logic [ADDR_W-1:0] wr_addr;
	logic wr_last;
	logic [ADDR_W+1:0] wr_word;
	logic [MASK_W-1:0] lane_we;

	assign any_edge = link.k | link.k_n; // R16
	// Read wins a shared address edge; the write select is then dropped
	assign wr_start = true_in_edge & wr_sel & ~rd_sel & ~wr_act_q; // R1 R8 R10
	// Beat 0 lands on the select edge itself, no write latency
	assign wr_beat = wr_start | (wr_act_q & any_edge); // R2 R17
	assign wr_idx = wr_start ? SPDS_BEAT_FIRST : wr_cnt_q;
	assign wr_addr = wr_start ? link.addr : wr_addr_q;
	assign wr_last = (wr_cnt_q == SPDS_BEAT_LAST);
	assign wr_word = {wr_addr, wr_idx};

	generate
		for (genvar g = 0; g < MASK_W; g++) begin : g_we
			assign lane_we[g] = wr_beat & ~wmask_n[g]; // R4 R6 R7
		end
	endgenerate

	always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			wr_act_q <= 1'b0;
			wr_cnt_q <= SPDS_BEAT_FIRST;
			wr_addr_q <= '0;
		end else if (wr_start) begin
			wr_act_q <= 1'b1;
			wr_cnt_q <= SPDS_BEAT_NEXT;
			wr_addr_q <= link.addr; // R8
		end else if (wr_act_q && any_edge) begin
			wr_cnt_q <= wr_cnt_q + SPDS_BEAT_NEXT;
			if (wr_last) begin
				wr_act_q <= 1'b0; // R17
			end
		end
	end

	// Storage, per-lane write with mask of the same beat
	always_ff @(posedge clk_sys_in) begin
		for (int i = 0; i < MASK_W; i++) begin
			if (lane_we[i]) begin // R4 R6 R7
				mem[wr_word][i*LANE_W +: LANE_W] <= link.d[i*LANE_W +: LANE_W];
			end
		end
	end

	// ==========================================================
	// Read port
	spds_rd_state_t rd_st_q;
	logic [1:0] rd_cnt_q;
	logic [ADDR_W-1:0] rd_addr_q;
	logic rd_pend_q;
	logic [ADDR_W-1:0] rd_pend_addr_q;
	logic [DATA_W-1:0] q_q;
	logic q_oe_n_q;
	logic rd_take;
	logic out_true;
	logic burst_start;
	logic rd_bursting;
	logic rd_hold_end;
	logic rd_last;
	logic [ADDR_W+1:0] rd_first_word;
	logic [ADDR_W+1:0] rd_word;

	assign rd_take = true_in_edge & rd_sel & ~rd_pend_q; // R13 R8 R10
	assign out_true = link.single_clk_mode ? link.k : link.c; // R11
	assign rd_bursting = (rd_st_q == SPDS_RD_BURST);
	assign burst_start = out_true & rd_pend_q & ~rd_bursting;
	// Outputs stay driven when the next burst starts on the release edge
	assign rd_hold_end = (rd_st_q == SPDS_RD_HOLD) & out_true & ~burst_start; // R14
	assign rd_last = (rd_cnt_q == SPDS_BEAT_LAST);
	assign rd_first_word = {rd_pend_addr_q, SPDS_BEAT_FIRST};
	assign rd_word = {rd_addr_q, rd_cnt_q};

	// One read may wait here behind a running burst
	always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			rd_pend_q <= 1'b0;
			rd_pend_addr_q <= '0;
		end else if (rd_take) begin
			rd_pend_q <= 1'b1;
			rd_pend_addr_q <= link.addr;
		end else if (burst_start) begin
			rd_pend_q <= 1'b0;
		end
	end

	always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			rd_st_q <= SPDS_RD_IDLE;
			rd_cnt_q <= SPDS_BEAT_FIRST;
			rd_addr_q <= '0;
			q_q <= '0;
			q_oe_n_q <= SPDS_OE_OFF;
		end else begin
			case (rd_st_q)
				SPDS_RD_IDLE, SPDS_RD_HOLD: begin
					if (burst_start) begin
						q_q <= mem[rd_first_word]; // R11
						q_oe_n_q <= 1'b0;
						rd_cnt_q <= SPDS_BEAT_NEXT;
						rd_addr_q <= rd_pend_addr_q;
						rd_st_q <= SPDS_RD_BURST;
					end else if (rd_hold_end) begin
						q_oe_n_q <= SPDS_OE_OFF; // R12 R14
						rd_st_q <= SPDS_RD_IDLE;
					end
				end
				SPDS_RD_BURST: begin
					q_q <= mem[rd_word]; // R15
					rd_cnt_q <= rd_cnt_q + SPDS_BEAT_NEXT;
					if (rd_last) begin
						rd_st_q <= SPDS_RD_HOLD; // R14
					end
				end
				default: begin
					rd_st_q <= SPDS_RD_IDLE;
					q_oe_n_q <= SPDS_OE_OFF;
				end
			endcase
		end
	end

	// ==========================================================
	// Output pins
	assign link.q = q_q;
	assign link.q_oe_n = q_oe_n_q; // R12

	// ==========================================================
	// Status
	assign write_busy_out = wr_act_q;
	assign read_busy_out = rd_pend_q | (rd_st_q != SPDS_RD_IDLE);

endmodule

// file: src/spds_if.sv
/*
 * Pin link between the memory controller and the SRAM device.
 * Assumes every pin changes only on clk_sys_in; k high marks a cycle that
 * ends on a true input clock edge, k_n high one that ends on a complement edge.
 */
`timescale 1ns/10ps
interface spds_if #(
	parameter int DATA_W = 36,
	parameter int ADDR_W = 17
);
	logic k;
	logic k_n;
	logic c;
	logic c_n;
	logic single_clk_mode;
	logic write_port_select_n;
	logic read_port_select_n;
	logic [ADDR_W-1:0] addr;
	logic [DATA_W-1:0] d;
	logic [1:0] nibble_write_mask_n;
	logic [3:0] lane_write_mask_n;
	logic [DATA_W-1:0] q;
	logic q_oe_n;

	modport device (
		input k, k_n, c, c_n, single_clk_mode, write_port_select_n, read_port_select_n,
		input addr, d, nibble_write_mask_n, lane_write_mask_n,
		output q, q_oe_n
	);
	modport ctrl (
		output k, k_n, c, c_n, single_clk_mode, write_port_select_n, read_port_select_n,
		output addr, d, nibble_write_mask_n, lane_write_mask_n,
		input q, q_oe_n
	);
endinterface

// file: src/spds_pkg.sv
/*
 * Shared constants and types of the split-port DDR SRAM pin link.
 * Assumes both ends run on one system clock, one half clock period per cycle.
 */
package spds_pkg;

	// ==========================================================
	// Geometry
	localparam int SPDS_DATA_W = 36;
	localparam int SPDS_ADDR_W = 17;
	localparam int SPDS_BURST_LEN = 4;
	localparam int SPDS_BEAT_W = 2;
	localparam int SPDS_NIB_CFG_W = 8;
	localparam int SPDS_NIB_W = 4;
	localparam int SPDS_LANE_W = 9;
	localparam int SPDS_NIB_MASK_W = 2;
	localparam int SPDS_LANE_MASK_W = 4;

	// ==========================================================
	// Beat numbers and idle pin levels
	localparam logic [1:0] SPDS_BEAT_FIRST = 2'h0;
	localparam logic [1:0] SPDS_BEAT_NEXT = 2'h1;
	localparam logic [1:0] SPDS_BEAT_LAST = 2'h3;
	localparam logic SPDS_SEL_IDLE = 1'h1;
	localparam logic SPDS_OE_OFF = 1'h1;

	// ==========================================================
	// Read port states, Gray along idle, burst, hold
	typedef enum logic [1:0] {
		SPDS_RD_IDLE = 2'h0,
		SPDS_RD_BURST = 2'h1,
		SPDS_RD_HOLD = 2'h3
	} spds_rd_state_t;

endpackage

// file: testbench/spds_link_sva.sv
/*
 * Pin checks of the split-port link between controller and device.
 * Assumes the bench instantiates it beside the link interface.
 */
`timescale 1ns/10ps
module spds_link_sva #(
	parameter int DATA_W = 36,
	parameter int ADDR_W = 17
) (
	// Clock and reset
	input wire logic clk_sys_in,
	input wire logic rst_b_in,
	// Link
	input wire logic k,
	input wire logic k_n,
	input wire logic c,
	input wire logic c_n,
	input wire logic write_port_select_n,
	input wire logic read_port_select_n,
	input wire logic [1:0] nibble_write_mask_n,
	input wire logic q_oe_n
);
	default clocking cb @(posedge clk_sys_in);
	endclocking
	default disable iff (!rst_b_in);

	// ==========================================================
	// Assertions
	clk_pair_a: assert property (k |=> !k ##1 k && c && !c_n && !k_n)
		else $error("link clocks out of phase");
	wsel_edge_a: assert property (!write_port_select_n |-> k)
		else $error("write select off the true edge");
	rsel_edge_a: assert property (!read_port_select_n |-> k)
		else $error("read select off the true edge");
	wr_beats_a: assert property (!write_port_select_n |=> write_port_select_n[*3])
		else $error("write select inside a burst");
	rd_start_a: assert property (!read_port_select_n && q_oe_n |-> ##3 !q_oe_n)
		else $error("read data late");
	rd_burst_a: assert property ($fell(q_oe_n) |-> !q_oe_n[*4])
		else $error("read burst short");
	rd_release_a: assert property ($rose(q_oe_n) |-> !k && $past(read_port_select_n, 3))
		else $error("outputs released off the true edge");
	nib_idle_a: assert property (DATA_W == 8 || nibble_write_mask_n == 2'h3)
		else $error("nibble mask used in wide mode");

	cov_wr_c: cover property (!write_port_select_n);
	cov_rd_c: cover property ($rose(q_oe_n));
	cov_both_c: cover property (!read_port_select_n ##[1:8] !write_port_select_n);
endmodule

// file: testbench/split_port_ddr_sram_interface_bench.sv
/*
 * Bench for the split-port link: controller and device joined end to end.
 * Assumes the package and the link interface are compiled first.
 */
`timescale 1ns/10ps
module split_port_ddr_sram_interface_bench import spds_pkg::*;;
	localparam int AW = 4;
	localparam int DW = SPDS_DATA_W;
	typedef struct {logic [AW-1:0] a; logic [4*DW-1:0] d; logic [15:0] m;} spds_row_t;
	logic clk_sys_in, rst_b_in, wr_req_in, rd_req_in, wr_ready_out, rd_ready_out, rd_valid_out;
	logic [AW-1:0] wr_addr_in, rd_addr_in;
	logic [4*DW-1:0] wr_data_in, rd_data_out;
	logic [15:0] wr_mask_n_in;
	logic [DW-1:0] mem [16][4];
	logic wr_busy, rd_busy;
	int failures, n_checks;
	spds_row_t rows [4] = '{
		'{4'h3, {36'h3a5a5a5a5, 36'h2c3c3c3c3, 36'h1f0f0f0f0, 36'h012345678}, 16'h0000},
		'{4'hf, {36'h7fffffffe, 36'h800000001, 36'h6789abcde, 36'h55aa55aa5}, 16'h0000},
		'{4'h3, {36'h111111111, 36'h222222222, 36'h333333333, 36'h444444444}, 16'h5a3c},
		'{4'hf, {36'h999999999, 36'h888888888, 36'h777777777, 36'h666666666}, 16'hffff}};

	spds_if #(.DATA_W(DW), .ADDR_W(AW)) link_i ();
	spds_device #(.DATA_W(DW), .ADDR_W(AW)) spds_device_i (.clk_sys_in(clk_sys_in), .rst_b_in(rst_b_in),
		.link(link_i), .write_busy_out(wr_busy), .read_busy_out(rd_busy));
	spds_ctrl #(.DATA_W(DW), .ADDR_W(AW), .SINGLE_CLK(1'b0)) spds_ctrl_i (.clk_sys_in(clk_sys_in),
		.rst_b_in(rst_b_in), .link(link_i), .wr_req_in(wr_req_in), .wr_addr_in(wr_addr_in),
		.wr_data_in(wr_data_in), .wr_mask_n_in(wr_mask_n_in), .wr_ready_out(wr_ready_out),
		.rd_req_in(rd_req_in), .rd_addr_in(rd_addr_in), .rd_ready_out(rd_ready_out),
		.rd_data_out(rd_data_out), .rd_valid_out(rd_valid_out));
	spds_link_sva #(.DATA_W(DW), .ADDR_W(AW)) spds_link_sva_i (.clk_sys_in(clk_sys_in), .rst_b_in(rst_b_in),
		.k(link_i.k), .k_n(link_i.k_n), .c(link_i.c), .c_n(link_i.c_n),
		.write_port_select_n(link_i.write_port_select_n), .read_port_select_n(link_i.read_port_select_n),
		.nibble_write_mask_n(link_i.nibble_write_mask_n), .q_oe_n(link_i.q_oe_n));

	initial begin
		clk_sys_in = 1'b0;
		forever #2 clk_sys_in = ~clk_sys_in;
	end

	// ==========================================================
	// Tasks
	task automatic chk(input string what, input logic [4*DW-1:0] exp, input logic [4*DW-1:0] got);
		n_checks++;
		if (got !== exp) begin
			failures++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic finish_test();
		$display("checks %0d failures %0d", n_checks, failures);
		if (failures == 0 && n_checks > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask

	// Wait at falling edges for a level, bounded
	task automatic hs(ref logic sig, input string what, input int lim);
		int n;
		n = 0;
		while (sig !== 1'b1) begin
			@(negedge clk_sys_in);
			n++;
			if (n > lim) begin
				chk(what, 1, 0);
				finish_test();
			end
		end
	endtask

	task automatic wr(input spds_row_t r);
		wr_req_in = 1'b1;
		wr_addr_in = r.a;
		wr_data_in = r.d;
		wr_mask_n_in = r.m;
		hs(wr_ready_out, "wr_ready_out", 20);
		@(negedge clk_sys_in);
		wr_req_in = 1'b0;
		for (int b = 0; b < 4; b++) begin
			for (int l = 0; l < 4; l++) begin
				if (!r.m[b*4+l]) mem[r.a][b][l*9+:9] = r.d[b*DW+l*9+:9];
			end
		end
	endtask

	task automatic rd_issue(input logic [AW-1:0] a);
		rd_req_in = 1'b1;
		rd_addr_in = a;
		hs(rd_ready_out, "rd_ready_out", 20);
		@(negedge clk_sys_in);
		rd_req_in = 1'b0;
		@(negedge clk_sys_in);
	endtask

	task automatic rd_wait(input logic [AW-1:0] a);
		hs(rd_valid_out, "rd_valid_out", 30);
		chk("rd_data_out", {mem[a][3], mem[a][2], mem[a][1], mem[a][0]}, rd_data_out);
		@(negedge clk_sys_in);
	endtask

	// ==========================================================
	// Sequence
	initial begin
		rst_b_in = 1'b0;
		{wr_req_in, rd_req_in, wr_addr_in, rd_addr_in, wr_data_in, wr_mask_n_in} = '0;
		failures = 0;
		n_checks = 0;
		repeat (3) @(negedge clk_sys_in);
		chk("q_oe_n", 1, link_i.q_oe_n);
		chk("read_busy_out", 0, rd_busy);
		chk("write_busy_out", 0, wr_busy);
		rst_b_in = 1'b1;
		@(negedge clk_sys_in);
		$display("reset done");
		for (int i = 0; i < 4; i++) begin
			wr(rows[i]);
			rd_issue(rows[i].a);
			rd_wait(rows[i].a);
			chk("q_oe_n", 1, link_i.q_oe_n);
			chk("read_busy_out", 0, rd_busy);
			chk("write_busy_out", 0, wr_busy);
			$display("row %0d done", i);
		end
		rd_issue(4'h3);
		rd_issue(4'hf);
		rd_wait(4'h3);
		rd_wait(4'hf);
		$display("back to back reads done");
		fork
			wr(rows[1]);
			rd_issue(4'h3);
		join
		rd_wait(4'h3);
		rd_issue(4'hf);
		rd_wait(4'hf);
		$display("shared address bus done");
		// Reset in mid-burst; memory keeps its contents
		rd_issue(4'h3);
		repeat (4) @(negedge clk_sys_in);
		chk("q_oe_n", 0, link_i.q_oe_n);
		rst_b_in = 1'b0;
		@(negedge clk_sys_in);
		chk("q_oe_n", 1, link_i.q_oe_n);
		chk("rd_valid_out", 0, rd_valid_out);
		chk("read_busy_out", 0, rd_busy);
		rst_b_in = 1'b1;
		@(negedge clk_sys_in);
		rd_issue(4'hf);
		rd_wait(4'hf);
		$display("reset mid-run done");
		finish_test();
	end
endmodule
